// [logic/bcc_pkg.sv]
// package: offsets, field positions, reset values and timing counts of the bridge control registers
package bcc_pkg;
   // ---------------------------------------------------------------
   // register byte offsets
   // ---------------------------------------------------------------
   localparam logic [7:0] OFS_CHIP_CTRL0  = 8'h40;
   localparam logic [7:0] OFS_RSVD44      = 8'h44;
   localparam logic [7:0] OFS_ARB_EN      = 8'h48;
   localparam logic [7:0] OFS_IRQ_STATUS  = 8'h50;
   localparam logic [7:0] OFS_IRQ_MASK    = 8'h54;
   localparam logic [7:0] OFS_LINK_STATUS = 8'h58;

   // ---------------------------------------------------------------
   // field positions of chip_control_zero
   // ---------------------------------------------------------------
   localparam int FC_UPD_BIT     = 15;
   localparam int RETRY_EXP_BIT  = 16;
   localparam int RETRY_LIM_LO   = 17;
   localparam int DISC_DIS_BIT   = 19;
   localparam int DISC_SHORT_BIT = 20;
   localparam int CFG_RT_LO      = 21;
   localparam int DLY_ORD_BIT    = 23;
   localparam int CPL_T_LO       = 24;
   localparam int ISO_EN_BIT     = 26;
   localparam int ISO_TC_LO      = 27;
   localparam int PS_L1_BIT      = 30;
   localparam int PS_L0S_BIT     = 31;

   // writable bits of chip_control_zero (15, 17..31); bit 16 is write-one-to-clear
   localparam logic [31:0] CC0_RW_MASK  = 32'hFFFE_8000;
   localparam logic [31:0] CC0_RESET    = 32'hC920_0000;
   localparam logic [4:0]  ARB_EN_RESET = 5'h1F;
   localparam logic [31:0] RSVD44_VALUE = 32'h0000_0000;

   // ---------------------------------------------------------------
   // retry limits, discard and timer lengths
   // ---------------------------------------------------------------
   localparam logic [31:0] RETRY_LIM_256 = 32'h0000_0100;
   localparam logic [31:0] RETRY_LIM_64K = 32'h0001_0000;
   localparam logic [31:0] RETRY_LIM_2G  = 32'h8000_0000;
   localparam logic [7:0]  DISC_SHORT_CLKS = 8'h40;
   localparam logic [2:0]  TC_ZERO        = 3'h0;

   localparam int CLK_NS         = 50;
   localparam int CFG_T0_US      = 25;
   localparam int CFG_T1_US      = 500;
   localparam int CFG_T2_US      = 5000;
   localparam int CFG_T3_US      = 25000;
   localparam int CPL_T0_US      = 50;
   localparam int CPL_T1_US      = 10000;
   localparam int CPL_T2_US      = 50000;
   localparam int CFG_T0_CYC     = CFG_T0_US * 1000 / CLK_NS;
   localparam int CFG_T1_CYC     = CFG_T1_US * 1000 / CLK_NS;
   localparam int CFG_T2_CYC     = CFG_T2_US * 1000 / CLK_NS;
   localparam int CFG_T3_CYC     = CFG_T3_US * 1000 / CLK_NS;
   localparam int CPL_T0_CYC     = CPL_T0_US * 1000 / CLK_NS;
   localparam int CPL_T1_CYC     = CPL_T1_US * 1000 / CLK_NS;
   localparam int CPL_T2_CYC     = CPL_T2_US * 1000 / CLK_NS;

   // interrupt status layout
   localparam int IRQ_RETRY_BIT  = 0;
   localparam int IRQ_CFG_BIT    = 1;
   localparam int IRQ_CPL_BIT    = 2;
   localparam int IRQ_DISC_BIT   = 3;

   localparam logic [1:0] AXI_OKAY   = 2'h0;
   localparam logic [1:0] AXI_SLVERR = 2'h2;

   typedef enum logic [2:0] {
      LP_L0  = 3'b001,
      LP_L0S = 3'b010,
      LP_L1  = 3'b100
   } bcc_lpstate_t;
endpackage

// [logic/bcc_top.sv]
// bridge chip control registers with AXI4-Lite slave, retry, discard and timers
//
// Notes on behaviour
// RQ1: bit 15 clear sends credit update every two freed credits, set every one.
// RQ2: bit 16 set by hardware on retry expiry, cleared by writing one.
// RQ3: bits 18:17 pick retry limit: none, 256, 64K or 2G retries.
// RQ4: bit 19 set disables discard timer; clear enables it with bridge control bits.
// RQ5: bit 20 set gives 64-clock discard expiry, else bridge control bit 25.
// RQ6: bits 22:21 pick config retry timer 25us, 0.5ms, 5ms, 25ms; reset 01.
// RQ7: bit 23 set forbids out-of-order completion among delayed transactions.
// RQ8: bits 25:24 pick completion timer 50us, 10ms, 50ms or off; reset 01.
// RQ9: bit 26 clear maps forwarded memory traffic to TC0, set uses bits 29:27.
// RQ10: bits 29:27 hold isochronous traffic class, reset 001, used when enabled.
// RQ11: bit 30 set gates internal clocks while link is in L1 or L1s; the code gates them in L1 only.
// RQ12: bit 31 set enables power saving in L0s; resets to one.
// RQ13: register at 44h reads as all zeros.
// RQ14: bits 4:0 at 48h enable arbitration per requester; reset to ones.
// RQ15: bits 8:5 at 48h read as zero.
// RQ16: writes to reserved read-only bits change nothing.
// RQ17: at retry limit, retrying stops and expiry flag sets same cycle.
//
// Decided for this implementation: register access over AXI4-Lite.
`timescale 1ns/10ps
`default_nettype none
module bcc_top
   import bcc_pkg::*;
#(
   parameter int CFG_T0_P = CFG_T0_CYC,
   parameter int CFG_T1_P = CFG_T1_CYC,
   parameter int CFG_T2_P = CFG_T2_CYC,
   parameter int CFG_T3_P = CFG_T3_CYC,
   parameter int CPL_T0_P = CPL_T0_CYC,
   parameter int CPL_T1_P = CPL_T1_CYC,
   parameter int CPL_T2_P = CPL_T2_CYC
) (
   // clock and reset
   input  wire logic        CLK_SYS,
   input  wire logic        RESETN,
   // axi4-lite write address
   input  wire logic [7:0]  S_AXI_AWADDR,
   input  wire logic        S_AXI_AWVALID,
   output logic             S_AXI_AWREADY,
   // axi4-lite write data
   input  wire logic [31:0] S_AXI_WDATA,
   input  wire logic [3:0]  S_AXI_WSTRB,
   input  wire logic        S_AXI_WVALID,
   output logic             S_AXI_WREADY,
   // axi4-lite write response
   output logic [1:0]       S_AXI_BRESP,
   output logic             S_AXI_BVALID,
   input  wire logic        S_AXI_BREADY,
   // axi4-lite read
   input  wire logic [7:0]  S_AXI_ARADDR,
   input  wire logic        S_AXI_ARVALID,
   output logic             S_AXI_ARREADY,
   output logic [31:0]      S_AXI_RDATA,
   output logic [1:0]       S_AXI_RRESP,
   output logic             S_AXI_RVALID,
   input  wire logic        S_AXI_RREADY,
   // bridge core events and state
   input  wire logic        CREDIT_FREED,
   input  wire logic        RETRY_SEEN,
   input  wire logic        RETRY_DONE,
   input  wire logic        DISC_START,
   input  wire logic        DISC_STOP,
   input  wire logic        BRG_DISC_EN,
   input  wire logic        BRG_DISC_LONG,
   input  wire logic        CFG_START,
   input  wire logic        CFG_STOP,
   input  wire logic        CPL_START,
   input  wire logic        CPL_STOP,
   input  wire logic [2:0]  LINK_PSTATE,
   // controls to the bridge core
   output logic             FC_UPDATE,
   output logic             RETRY_ABORT,
   output logic             DISC_EXPIRED,
   output logic             CFG_EXPIRED,
   output logic             CPL_EXPIRED,
   output logic             STRICT_ORDER,
   output logic [2:0]       MEM_TC,
   output logic             CLK_GATE,
   output logic             L0S_SAVE,
   output logic [4:0]       ARB_ENABLE,
   output logic             IRQ
);
   // ---------------------------------------------------------------
   // register storage
   // ---------------------------------------------------------------
   logic [31:0] cc0_reg;
   logic [4:0]  arb_reg;
   logic [3:0]  irq_stat_reg;
   logic [3:0]  irq_mask_reg;
   logic        aw_got_reg, w_got_reg;
   logic [7:0]  aw_addr_reg;
   logic [31:0] w_data_reg;
   logic [3:0]  w_strb_reg;
   logic        wr_fire;
   logic        retry_exp_set;
   logic [3:0]  irq_events;

   // ---------------------------------------------------------------
   // write channel: address and data taken in either order
   // ---------------------------------------------------------------
   assign wr_fire = aw_got_reg && w_got_reg && !S_AXI_BVALID;

   always_ff @(posedge CLK_SYS or negedge RESETN) begin
      if (!RESETN) begin
         aw_got_reg    <= 1'b0;
         aw_addr_reg   <= 8'h00;
         S_AXI_AWREADY <= 1'b0;
      end else begin
         S_AXI_AWREADY <= !aw_got_reg && !S_AXI_AWREADY && S_AXI_AWVALID;
         if (S_AXI_AWVALID && S_AXI_AWREADY) begin
            aw_got_reg  <= 1'b1;
            aw_addr_reg <= S_AXI_AWADDR;
         end else if (wr_fire) begin
            aw_got_reg <= 1'b0;
         end
      end
   end

   always_ff @(posedge CLK_SYS or negedge RESETN) begin
      if (!RESETN) begin
         w_got_reg    <= 1'b0;
         w_data_reg   <= 32'h0000_0000;
         w_strb_reg   <= 4'h0;
         S_AXI_WREADY <= 1'b0;
      end else begin
         S_AXI_WREADY <= !w_got_reg && !S_AXI_WREADY && S_AXI_WVALID;
         if (S_AXI_WVALID && S_AXI_WREADY) begin
            w_got_reg  <= 1'b1;
            w_data_reg <= S_AXI_WDATA;
            w_strb_reg <= S_AXI_WSTRB;
         end else if (wr_fire) begin
            w_got_reg <= 1'b0;
         end
      end
   end

   always_ff @(posedge CLK_SYS or negedge RESETN) begin
      if (!RESETN) begin
         S_AXI_BVALID <= 1'b0;
         S_AXI_BRESP  <= AXI_OKAY;
      end else if (wr_fire) begin
         S_AXI_BVALID <= 1'b1;
         case (aw_addr_reg[7:2])
            OFS_CHIP_CTRL0[7:2], OFS_RSVD44[7:2], OFS_ARB_EN[7:2],
            OFS_IRQ_STATUS[7:2], OFS_IRQ_MASK[7:2], OFS_LINK_STATUS[7:2]:
               S_AXI_BRESP <= AXI_OKAY;
            default:
               S_AXI_BRESP <= AXI_SLVERR;
         endcase
      end else if (S_AXI_BREADY) begin
         S_AXI_BVALID <= 1'b0;
      end
   end

   // byte-lane mask from strobes
   logic [31:0] wmask;
   always_comb begin
      for (int i = 0; i < 4; i++) begin
         wmask[8*i +: 8] = {8{w_strb_reg[i]}};
      end
   end

   logic wr_cc0, wr_arb, wr_stat, wr_mask;
   assign wr_cc0  = wr_fire && (aw_addr_reg[7:2] == OFS_CHIP_CTRL0[7:2]);
   assign wr_arb  = wr_fire && (aw_addr_reg[7:2] == OFS_ARB_EN[7:2]);
   assign wr_stat = wr_fire && (aw_addr_reg[7:2] == OFS_IRQ_STATUS[7:2]);
   assign wr_mask = wr_fire && (aw_addr_reg[7:2] == OFS_IRQ_MASK[7:2]);

   // ---------------------------------------------------------------
   // chip_control_zero
   // ---------------------------------------------------------------
   logic [31:0] cc0_wen;
   assign cc0_wen = wmask & CC0_RW_MASK; // [RQ16]

   always_ff @(posedge CLK_SYS or negedge RESETN) begin
      if (!RESETN) begin
         cc0_reg <= CC0_RESET; // [RQ6] [RQ8] [RQ10] [RQ11] [RQ12]
      end else begin
         if (wr_cc0) begin
            cc0_reg <= (cc0_reg & ~cc0_wen) | (w_data_reg & cc0_wen);
         end
         // set wins over a one written in the same cycle
         if (retry_exp_set) begin
            cc0_reg[RETRY_EXP_BIT] <= 1'b1; // [RQ2] [RQ17]
         end else if (wr_cc0 && w_strb_reg[2] && w_data_reg[RETRY_EXP_BIT]) begin
            cc0_reg[RETRY_EXP_BIT] <= 1'b0; // [RQ2]
         end
      end
   end

   // only the five enables are stored; bits 8:5 stay zero
   always_ff @(posedge CLK_SYS or negedge RESETN) begin
      if (!RESETN) begin
         arb_reg <= ARB_EN_RESET; // [RQ14]
      end else if (wr_arb && w_strb_reg[0]) begin
         arb_reg <= w_data_reg[4:0]; // [RQ14] [RQ15]
      end
   end

   // ---------------------------------------------------------------
   // flow-control update pacing
   // ---------------------------------------------------------------
   logic credit_odd_reg;
   always_ff @(posedge CLK_SYS or negedge RESETN) begin
      if (!RESETN) begin
         credit_odd_reg <= 1'b0;
         FC_UPDATE      <= 1'b0;
      end else begin
         FC_UPDATE <= 1'b0;
         if (CREDIT_FREED) begin
            if (cc0_reg[FC_UPD_BIT] || credit_odd_reg) begin
               FC_UPDATE      <= 1'b1; // [RQ1]
               credit_odd_reg <= 1'b0;
            end else begin
               credit_odd_reg <= 1'b1; // [RQ1]
            end
         end
      end
   end

   // ---------------------------------------------------------------
   // retry counter
   // ---------------------------------------------------------------
   logic [31:0] retry_cnt_reg;
   logic [31:0] retry_limit;
   logic [1:0]  retry_sel;
   assign retry_sel = cc0_reg[RETRY_LIM_LO +: 2];
   always_comb begin
      unique case (retry_sel)
         2'h0: retry_limit = 32'h0000_0000;
         2'h1: retry_limit = RETRY_LIM_256;
         2'h2: retry_limit = RETRY_LIM_64K;
         2'h3: retry_limit = RETRY_LIM_2G;
      endcase
   end
   // the retry that reaches the limit is the one refused
   assign retry_exp_set = RETRY_SEEN && (retry_sel != 2'h0)
                          && ((retry_cnt_reg + 32'h1) >= retry_limit); // [RQ3] [RQ17]

   always_ff @(posedge CLK_SYS or negedge RESETN) begin
      if (!RESETN) begin
         retry_cnt_reg <= 32'h0000_0000;
         RETRY_ABORT   <= 1'b0;
      end else begin
         RETRY_ABORT <= retry_exp_set; // [RQ17]
         if (RETRY_DONE || retry_exp_set) begin
            retry_cnt_reg <= 32'h0000_0000;
         end else if (RETRY_SEEN && retry_cnt_reg != 32'hFFFF_FFFF) begin
            retry_cnt_reg <= retry_cnt_reg + 32'h1;
         end
      end
   end

   // ---------------------------------------------------------------
   // discard timer, in core clocks
   // ---------------------------------------------------------------
   logic [15:0] disc_cnt_reg;
   logic        disc_run_reg;
   logic [15:0] disc_len;
   logic        disc_on;
   assign disc_on  = BRG_DISC_EN && !cc0_reg[DISC_DIS_BIT]; // [RQ4]
   // long/short choice from the bridge control register (2^15 or 2^10 clocks)
   assign disc_len = cc0_reg[DISC_SHORT_BIT] ? {8'h00, DISC_SHORT_CLKS}
                   : (BRG_DISC_LONG ? 16'h8000 : 16'h0400); // [RQ5]
   always_ff @(posedge CLK_SYS or negedge RESETN) begin
      if (!RESETN) begin
         disc_cnt_reg <= 16'h0000;
         disc_run_reg <= 1'b0;
         DISC_EXPIRED <= 1'b0;
      end else begin
         DISC_EXPIRED <= 1'b0;
         if (DISC_STOP || !disc_on) begin
            disc_run_reg <= 1'b0;
         end else if (DISC_START) begin
            disc_run_reg <= 1'b1;
            disc_cnt_reg <= 16'h0001;
         end else if (disc_run_reg) begin
            if (disc_cnt_reg >= disc_len) begin
               DISC_EXPIRED <= 1'b1; // [RQ4] [RQ5]
               disc_run_reg <= 1'b0;
            end else begin
               disc_cnt_reg <= disc_cnt_reg + 16'h1;
            end
         end
      end
   end

   // ---------------------------------------------------------------
   // configuration retry and completion timers
   // ---------------------------------------------------------------
   logic [20:0] cfg_cnt_reg, cpl_cnt_reg, cfg_len, cpl_len;
   logic        cfg_run_reg, cpl_run_reg;
   always_comb begin
      unique case (cc0_reg[CFG_RT_LO +: 2])
         2'h0: cfg_len = 21'(CFG_T0_P); // [RQ6]
         2'h1: cfg_len = 21'(CFG_T1_P);
         2'h2: cfg_len = 21'(CFG_T2_P);
         2'h3: cfg_len = 21'(CFG_T3_P);
      endcase
      unique case (cc0_reg[CPL_T_LO +: 2])
         2'h0: cpl_len = 21'(CPL_T0_P); // [RQ8]
         2'h1: cpl_len = 21'(CPL_T1_P);
         2'h2: cpl_len = 21'(CPL_T2_P);
         2'h3: cpl_len = 21'h1F_FFFF;
      endcase
   end
   always_ff @(posedge CLK_SYS or negedge RESETN) begin
      if (!RESETN) begin
         cfg_cnt_reg <= 21'h0;
         cfg_run_reg <= 1'b0;
         CFG_EXPIRED <= 1'b0;
      end else begin
         CFG_EXPIRED <= 1'b0;
         if (CFG_STOP) begin
            cfg_run_reg <= 1'b0;
         end else if (CFG_START) begin
            cfg_run_reg <= 1'b1;
            cfg_cnt_reg <= 21'h1;
         end else if (cfg_run_reg) begin
            if (cfg_cnt_reg >= cfg_len) begin
               CFG_EXPIRED <= 1'b1; // [RQ6]
               cfg_run_reg <= 1'b0;
            end else begin
               cfg_cnt_reg <= cfg_cnt_reg + 21'h1;
            end
         end
      end
   end

   always_ff @(posedge CLK_SYS or negedge RESETN) begin
      if (!RESETN) begin
         cpl_cnt_reg <= 21'h0;
         cpl_run_reg <= 1'b0;
         CPL_EXPIRED <= 1'b0;
      end else begin
         CPL_EXPIRED <= 1'b0;
         if (CPL_STOP || cc0_reg[CPL_T_LO +: 2] == 2'h3) begin
            cpl_run_reg <= 1'b0; // [RQ8]
         end else if (CPL_START) begin
            cpl_run_reg <= 1'b1;
            cpl_cnt_reg <= 21'h1;
         end else if (cpl_run_reg) begin
            if (cpl_cnt_reg >= cpl_len) begin
               CPL_EXPIRED <= 1'b1; // [RQ8]
               cpl_run_reg <= 1'b0;
            end else begin
               cpl_cnt_reg <= cpl_cnt_reg + 21'h1;
            end
         end
      end
   end

   // ---------------------------------------------------------------
   // static controls to the core
   // ---------------------------------------------------------------
   bcc_lpstate_t lp;
   assign lp = bcc_lpstate_t'(LINK_PSTATE);
   always_ff @(posedge CLK_SYS or negedge RESETN) begin
      if (!RESETN) begin
         STRICT_ORDER <= 1'b0;
         MEM_TC       <= TC_ZERO;
         CLK_GATE     <= 1'b0;
         L0S_SAVE     <= 1'b0;
         ARB_ENABLE   <= ARB_EN_RESET;
      end else begin
         STRICT_ORDER <= cc0_reg[DLY_ORD_BIT]; // [RQ7]
         MEM_TC       <= cc0_reg[ISO_EN_BIT] ? cc0_reg[ISO_TC_LO +: 3] : TC_ZERO; // [RQ9] [RQ10]
         CLK_GATE     <= cc0_reg[PS_L1_BIT] && (lp == LP_L1); // [RQ11]
         L0S_SAVE     <= cc0_reg[PS_L0S_BIT] && (lp == LP_L0S); // [RQ12]
         ARB_ENABLE   <= arb_reg; // [RQ14]
      end
   end

   // ---------------------------------------------------------------
   // interrupts
   // ---------------------------------------------------------------
   assign irq_events = {DISC_EXPIRED, CPL_EXPIRED, CFG_EXPIRED, retry_exp_set};
   always_ff @(posedge CLK_SYS or negedge RESETN) begin
      if (!RESETN) begin
         irq_stat_reg <= 4'h0;
         irq_mask_reg <= 4'h0;
         IRQ          <= 1'b0;
      end else begin
         irq_stat_reg <= (irq_stat_reg
                          & ~((wr_stat && w_strb_reg[0]) ? w_data_reg[3:0] : 4'h0))
                         | irq_events;
         if (wr_mask && w_strb_reg[0]) begin
            irq_mask_reg <= w_data_reg[3:0];
         end
         IRQ <= |(irq_stat_reg & irq_mask_reg);
      end
   end

   // ---------------------------------------------------------------
   // read channel
   // ---------------------------------------------------------------
   logic [31:0] rd_word;
   logic        rd_ok;
   always_comb begin
      rd_word = 32'h0000_0000;
      rd_ok   = 1'b1;
      case (S_AXI_ARADDR[7:2])
         OFS_CHIP_CTRL0[7:2]:  rd_word = cc0_reg & (CC0_RW_MASK | 32'h0001_0000);
         OFS_RSVD44[7:2]:      rd_word = RSVD44_VALUE; // [RQ13]
         OFS_ARB_EN[7:2]:      rd_word = {27'h0, arb_reg}; // [RQ15]
         OFS_IRQ_STATUS[7:2]:  rd_word = {28'h0, irq_stat_reg};
         OFS_IRQ_MASK[7:2]:    rd_word = {28'h0, irq_mask_reg};
         OFS_LINK_STATUS[7:2]: rd_word = {24'h0, disc_run_reg, cpl_run_reg, cfg_run_reg,
                                          credit_odd_reg, 1'b0, LINK_PSTATE};
         default:              rd_ok   = 1'b0;
      endcase
   end

   always_ff @(posedge CLK_SYS or negedge RESETN) begin
      if (!RESETN) begin
         S_AXI_ARREADY <= 1'b0;
         S_AXI_RVALID  <= 1'b0;
         S_AXI_RDATA   <= 32'h0000_0000;
         S_AXI_RRESP   <= AXI_OKAY;
      end else begin
         S_AXI_ARREADY <= S_AXI_ARVALID && !S_AXI_ARREADY && !S_AXI_RVALID;
         if (S_AXI_ARVALID && S_AXI_ARREADY) begin
            S_AXI_RVALID <= 1'b1;
            S_AXI_RDATA  <= rd_word;
            S_AXI_RRESP  <= rd_ok ? AXI_OKAY : AXI_SLVERR;
         end else if (S_AXI_RREADY) begin
            S_AXI_RVALID <= 1'b0;
         end
      end
   end
endmodule
`default_nettype wire

// [verification/bcc_properties.sv]
// checker: port assertions of the bridge control registers
`timescale 1ns/10ps
`default_nettype none
module bcc_properties (
   // clock, reset and bus handshakes
   input wire logic       CLK_SYS,
   input wire logic       RESETN,
   input wire logic       S_AXI_AWVALID,
   input wire logic       S_AXI_AWREADY,
   input wire logic       S_AXI_WVALID,
   input wire logic       S_AXI_WREADY,
   input wire logic       S_AXI_BVALID,
   input wire logic       S_AXI_ARVALID,
   input wire logic       S_AXI_ARREADY,
   input wire logic       S_AXI_RVALID,
   // core events and controls
   input wire logic       CREDIT_FREED,
   input wire logic       FC_UPDATE,
   input wire logic       RETRY_SEEN,
   input wire logic       RETRY_ABORT,
   input wire logic       DISC_EXPIRED,
   input wire logic       STRICT_ORDER,
   input wire logic [2:0] MEM_TC,
   input wire logic [4:0] ARB_ENABLE
);
   default clocking cb @(posedge CLK_SYS); endclocking
   default disable iff (!RESETN);
   sequence wr_take;
      S_AXI_AWVALID && S_AXI_AWREADY && S_AXI_WVALID && S_AXI_WREADY;
   endsequence
   sequence rd_take;
      S_AXI_ARVALID && S_AXI_ARREADY;
   endsequence
   AST_WR_ANSWER: assert property (wr_take |-> ##[1:3] S_AXI_BVALID)
      else $error("write answer missing");
   AST_RD_ANSWER: assert property (rd_take |=> S_AXI_RVALID)
      else $error("read answer missing");
   AST_ARB_RST: assert property ($rose(RESETN) |-> ##1 ARB_ENABLE == 5'h1F)
      else $error("arbiter enables not set after reset");
   AST_CTL_RST: assert property ($rose(RESETN) |-> ##1 (MEM_TC == 3'h0 && !STRICT_ORDER))
      else $error("control levels wrong after reset");
   // a credit pulse shows as an update one cycle later; the check also accepts a pulse two cycles back
   AST_FC_CAUSE: assert property (FC_UPDATE |-> $past(CREDIT_FREED) || $past(CREDIT_FREED, 2))
      else $error("update without freed credit");
   AST_ABORT_CAUSE: assert property (RETRY_ABORT |-> $past(RETRY_SEEN))
      else $error("abort without retry");
   AST_ABORT_PULSE: assert property (RETRY_ABORT |=> !RETRY_ABORT)
      else $error("abort longer than one cycle");
   AST_DISC_PULSE: assert property (DISC_EXPIRED |=> !DISC_EXPIRED)
      else $error("discard expiry longer than one cycle");
endmodule
bind bcc_top bcc_properties i_bcc_properties (
   .CLK_SYS, .RESETN, .S_AXI_AWVALID, .S_AXI_AWREADY, .S_AXI_WVALID, .S_AXI_WREADY,
   .S_AXI_BVALID, .S_AXI_ARVALID, .S_AXI_ARREADY, .S_AXI_RVALID, .CREDIT_FREED,
   .FC_UPDATE, .RETRY_SEEN, .RETRY_ABORT, .DISC_EXPIRED, .STRICT_ORDER, .MEM_TC, .ARB_ENABLE);
`default_nettype wire

// [verification/test_bcc_top.sv]
// self-checking bench of the bridge control registers
`timescale 1ns/10ps
`default_nettype none
module test_bcc_top;
   import bcc_pkg::*;
   localparam int LIM = 1100;
   localparam int CF [4] = '{CFG_T0_CYC, 30, 40, 50};
   localparam int CP [4] = '{CPL_T0_CYC, 70, 80, LIM};
   logic        clk = 1'h0, rstn = 1'h0, awv = 1'h0, wv = 1'h0, br = 1'h0, arv = 1'h0;
   logic        rr = 1'h0, awr, wrdy, bv, arr, rv, fc, ab, strict, irq, cg, ls;
   logic        den = 1'h1, dl = 1'h0;
   logic [3:0]  ws = 4'hF;
   logic [7:0]  aw = 8'h00, ar = 8'h00;
   logic [31:0] wd = 32'h0, rdata, v;
   logic [5:0]  ev = 6'h00;
   logic [1:0]  bresp, rresp;
   logic [2:0]  xp, tc, lps = LP_L0;
   logic [4:0]  arb;
   logic [33:0] rq [$], bq [$];
   int          n_errors = 0, cmp_count = 0, n_fc = 0, n_ab = 0, cyc = 0, b, n;
   // one stop line ends every run and clears the retry count
   bcc_top #(.CFG_T1_P(30), .CFG_T2_P(40), .CFG_T3_P(50), .CPL_T1_P(70),
      .CPL_T2_P(80)) i_bcc_top (
      .CLK_SYS(clk), .RESETN(rstn), .S_AXI_AWADDR(aw), .S_AXI_AWVALID(awv), .S_AXI_AWREADY(awr),
      .S_AXI_WDATA(wd), .S_AXI_WSTRB(ws), .S_AXI_WVALID(wv), .S_AXI_WREADY(wrdy),
      .S_AXI_BRESP(bresp), .S_AXI_BVALID(bv), .S_AXI_BREADY(br), .S_AXI_ARADDR(ar),
      .S_AXI_ARVALID(arv), .S_AXI_ARREADY(arr), .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp),
      .S_AXI_RVALID(rv), .S_AXI_RREADY(rr), .CREDIT_FREED(ev[0]), .RETRY_SEEN(ev[1]),
      .RETRY_DONE(ev[5]), .DISC_START(ev[2]), .DISC_STOP(ev[5]), .BRG_DISC_EN(den),
      .BRG_DISC_LONG(dl), .CFG_START(ev[3]), .CFG_STOP(ev[5]), .CPL_START(ev[4]),
      .CPL_STOP(ev[5]), .LINK_PSTATE(lps), .FC_UPDATE(fc), .RETRY_ABORT(ab),
      .DISC_EXPIRED(xp[0]), .CFG_EXPIRED(xp[1]), .CPL_EXPIRED(xp[2]), .STRICT_ORDER(strict),
      .MEM_TC(tc), .CLK_GATE(cg), .L0S_SAVE(ls), .ARB_ENABLE(arb), .IRQ(irq));
   task automatic give_verdict();
      if (n_errors == 0 && cmp_count > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask
   task automatic chk(input logic [33:0] e, input logic [33:0] a);
      cmp_count++;
      if (a !== e) begin
         n_errors++;
         $display("wrong value at %0t: expected %h got %h", $time, e, a);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
      logic ad = 1'h0, dd = 1'h0;
      bq.push_back(r);
      aw <= a;
      wd <= d;
      awv <= 1'h1;
      wv <= 1'h1;
      br <= 1'h1;
      // each channel is released at its own ready
      do begin
         @(posedge clk);
         ad |= awr;
         dd |= wrdy;
         if (awr)
            awv <= 1'h0;
         if (wrdy)
            wv <= 1'h0;
      end while (!(ad && dd));
      do @(posedge clk); while (!bv);
      br <= 1'h0;
      @(posedge clk);
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r = AXI_OKAY);
      rq.push_back({r, d});
      ar <= a;
      arv <= 1'h1;
      rr <= 1'h1;
      do @(posedge clk); while (!arr);
      arv <= 1'h0;
      do @(posedge clk); while (!rv);
      rr <= 1'h0;
      @(posedge clk);
   endtask
   // three idle edges let registered replies settle before any check
   task automatic pulse(input int k, input int cnt);
      repeat (cnt) begin
         ev[k] <= 1'h1;
         @(posedge clk);
         ev[k] <= 1'h0;
         repeat (3) @(posedge clk);
      end
   endtask
   task automatic lat(input int k, output int cnt);
      pulse(k, 1);
      cnt = 4;
      while (!xp[k-2] && cnt < LIM) begin
         @(posedge clk);
         cnt++;
      end
   endtask
   always #25 clk = ~clk;
   always @(posedge clk) begin
      cyc++;
      n_fc += fc;
      n_ab += ab;
      if (rv && rr)
         chk(rq.pop_front(), {rresp, rdata});
      if (bv && br)
         chk(bq.pop_front(), bresp);
      if (cyc == 20000) begin
         n_errors++;
         give_verdict();
      end
   end
   initial begin
      v = $urandom(6);
      repeat (2) @(posedge clk);
      rstn <= 1'h1;
      @(posedge clk);
      rd(OFS_CHIP_CTRL0, 32'hC920_0000);
      rd(OFS_ARB_EN, 32'h0000_001F);
      lps <= LP_L1;
      repeat (2) @(posedge clk);
      chk({cg, ls}, 2'h2);
      lps <= LP_L0S;
      repeat (2) @(posedge clk);
      chk({cg, ls}, 2'h1);
      wr(OFS_RSVD44, 32'hFFFF_FFFF, AXI_OKAY);
      rd(OFS_RSVD44, 32'h0);
      wr(8'h60, 32'h1, AXI_SLVERR);
      rd(8'h60, 32'h0, AXI_SLVERR);
      v = $urandom;
      wr(OFS_ARB_EN, v, AXI_OKAY);
      rd(OFS_ARB_EN, {27'h0, v[4:0]});
      chk(arb, v[4:0]);
      ws <= 4'hE;
      wr(OFS_ARB_EN, 32'h0, AXI_OKAY);
      ws <= 4'hF;
      rd(OFS_ARB_EN, {27'h0, v[4:0]});
      v = $urandom | 32'h0400_0000;
      wr(OFS_CHIP_CTRL0, v, AXI_OKAY);
      rd(OFS_CHIP_CTRL0, v & 32'hFFFE_8000);
      chk({strict, tc}, {v[23], v[29:27]});
      for (int i = 0; i < 2; i++) begin
         wr(OFS_CHIP_CTRL0, i << 15, AXI_OKAY);
         b = n_fc;
         pulse(0, 6);
         chk(n_fc - b, 3 * (i + 1));
      end
      chk({cg, ls}, 2'h0);
      wr(OFS_IRQ_MASK, 32'h1, AXI_OKAY);
      wr(OFS_CHIP_CTRL0, 32'h0002_0000, AXI_OKAY);
      pulse(5, 1);
      b = n_ab;
      pulse(1, 255);
      chk(n_ab - b, 0);
      pulse(1, 1);
      chk(n_ab - b, 1);
      chk(irq, 1'h1);
      rd(OFS_CHIP_CTRL0, 32'h0003_0000);
      wr(OFS_IRQ_MASK, 32'h0, AXI_OKAY);
      chk(irq, 1'h0);
      wr(OFS_IRQ_STATUS, 32'h1, AXI_OKAY);
      wr(OFS_CHIP_CTRL0, 32'h0001_0000, AXI_OKAY);
      rd(OFS_CHIP_CTRL0, 32'h0);
      wr(OFS_CHIP_CTRL0, 32'h0010_0000, AXI_OKAY);
      lat(2, n);
      chk(n >= 64 && n <= 66, 1'h1);
      den <= 1'h0;
      lat(2, n);
      chk(n, LIM);
      den <= 1'h1;
      wr(OFS_CHIP_CTRL0, 32'h0, AXI_OKAY);
      lat(2, n);
      chk(n >= 1024 && n <= 1026, 1'h1);
      wr(OFS_CHIP_CTRL0, 32'h0018_0000, AXI_OKAY);
      lat(2, n);
      chk(n, LIM);
      for (int i = 0; i < 4; i++) begin
         wr(OFS_CHIP_CTRL0, (i << 21) | (i << 24), AXI_OKAY);
         pulse(5, 1);
         lat(3, n);
         chk(n >= CF[i] && n <= CF[i] + 2, 1'h1);
         lat(4, n);
         chk(n >= CP[i] && n <= CP[i] + 2, 1'h1);
      end
      give_verdict();
   end
endmodule
`default_nettype wire
